// >>> src/ccdo_pkg.sv
// Package of opcodes, register layout and constants for the clear/complement/decrement execution block.
package ccdo_pkg;

  // ==========================================================================
  // Opcode encodings (14-bit instruction word)
  // ==========================================================================
  localparam logic [13:0] OP_WATCHDOG_CLEAR = 14'h0064;
  localparam logic [13:0] OP_CALL_VIA_W     = 14'h000a;
  localparam logic [13:0] OP_CLEAR_W        = 14'h0100;
  localparam logic [5:0]  OP6_COMPLEMENT    = 6'h09;
  localparam logic [5:0]  OP6_DECREMENT     = 6'h03;
  localparam logic [5:0]  OP6_DEC_SKIP      = 6'h0b;
  localparam logic [6:0]  OP7_CLEAR_FILE    = 7'h03;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int DEST_BIT      = 7;
  localparam int OP6_LSB       = 8;
  localparam int OP7_LSB       = 7;

  // ==========================================================================
  // Wishbone register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_INSTR   = 8'h00;
  localparam logic [7:0] ADDR_WREG    = 8'h04;
  localparam logic [7:0] ADDR_PC      = 8'h08;
  localparam logic [7:0] ADDR_PC_HIGH_LATCH  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_TOP     = 8'h14;
  localparam logic [7:0] ADDR_FILEDAT = 8'h18;
  localparam logic [7:0] ADDR_FILEOUT = 8'h1c;

  // ==========================================================================
  // Status field positions and reset values
  // ==========================================================================
  localparam int ST_ZERO     = 2;
  localparam int ST_POWERDN  = 3;
  localparam int ST_TIMEOUT  = 4;
  localparam logic [7:0]  STATUS_RST = 8'h18;
  localparam logic [14:0] PC_RST     = 15'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [7:0]  BYTE_ONE   = 8'h01;
  localparam logic [14:0] PC_ONE     = 15'h0001;

endpackage : ccdo_pkg

// >>> src/ccdo_wb_slave.sv
// Classic Wishbone slave front end: one-cycle ack and write strobe decode.
module ccdo_wb_slave
  import ccdo_pkg::*;
(
  input  wire logic        clk_i,    // Core clock.
  input  wire logic        rst_i,    // Synchronous reset, active high.
  input  wire logic        cyc_i,    // Bus cycle.
  input  wire logic        stb_i,    // Strobe.
  input  wire logic        we_i,     // Write enable.
  input  wire logic [3:0]  sel_i,    // Byte selects.
  input  wire logic [7:0]  adr_i,    // Byte address.
  input  wire logic [31:0] dat_i,    // Write data.
  input  wire logic [31:0] rdata_i,  // Read data from the core.
  output logic             ack_o,    // Acknowledge.
  output logic [31:0]      dat_o,    // Registered read data.
  output logic             wr_o,     // One-cycle write pulse.
  output logic             rd_o,     // One-cycle read pulse.
  output logic [7:0]       wadr_o,   // Address of the access.
  output logic [31:0]      wdat_o    // Write data passed through unchanged.
);

  logic        ack_ff;
  logic        nxt_ack;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;

  // ==========================================================================
  // Ack one cycle after the request, dropped the cycle after it is given.
  // ==========================================================================
  always_comb begin
    nxt_ack = cyc_i & stb_i & ~ack_ff;
    nxt_dat = nxt_ack ? rdata_i : dat_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end

  // The effect lands on the ack edge, the only edge the master commits on.
  assign ack_o  = ack_ff;
  assign dat_o  = dat_ff;
  assign wr_o   = ack_ff & we_i & sel_i[0];
  assign rd_o   = ack_ff & ~we_i;
  assign wadr_o = adr_i;
  assign wdat_o = dat_i;

endmodule : ccdo_wb_slave

// >>> src/ccdo_core.sv
// Execution block for watchdog clear, call via W, complement, clear and decrement instructions.
// Contract
// RULE1: Watchdog clear instruction zeroes the watchdog counter and its prescaler.
// RULE2: Watchdog clear sets timeout and powerdown flags, changes no other status.
// RULE3: Call via working pushes program counter plus one onto stack top.
// RULE4: Then W loads PC bits 7..0, high latch bits 6..0 load PC 14..8.
// RULE5: Call via working takes two cycles, status flags unchanged.
// RULE6: Destination bit zero writes W, one writes the addressed file register.
// RULE7: Complement file writes inverted file value, updates zero flag.
// RULE8: Clear file writes zero to file register and sets zero flag.
// RULE9: Clear working writes zero to W and sets zero flag.
// RULE10: Decrement file subtracts one, writes destination, updates zero flag.
// RULE11: Decrement skip writes result, no flags; zero result squashes next, two cycles.
// RULE12: Zero flag set when result is all zero; plain ops take one cycle.
//
// Our own choices: the Wishbone slave port and the register addresses.
module ccdo_core
  import ccdo_pkg::*;
(
  input  wire logic        clk_i,             // Core clock, 25 MHz.
  input  wire logic        rst_i,             // Synchronous reset, active high.
  input  wire logic        cyc_i,             // Wishbone cycle.
  input  wire logic        stb_i,             // Wishbone strobe.
  input  wire logic        we_i,              // Wishbone write enable.
  input  wire logic [3:0]  sel_i,             // Wishbone byte selects.
  input  wire logic [7:0]  adr_i,             // Wishbone byte address.
  input  wire logic [31:0] dat_i,             // Wishbone write data.
  output logic             ack_o,             // Wishbone acknowledge.
  output logic [31:0]      dat_o,             // Wishbone read data.
  output logic             wdt_clear_o,       // Pulse: clear watchdog counter.
  output logic             wdt_presc_clear_o, // Pulse: clear watchdog prescaler.
  output logic             stack_push_o,      // Pulse: push onto return stack.
  output logic [14:0]      stack_data_o,      // Return address being pushed.
  output logic             file_we_o,         // Pulse: file register write.
  output logic [6:0]       file_addr_o,       // File register address.
  output logic [7:0]       file_wdata_o,      // File register write data.
  output logic             busy_o             // Second cycle of a two-cycle instruction.
);

  // ==========================================================================
  // Bus front end
  // ==========================================================================
  logic        wr_p;
  logic        rd_p;
  logic [7:0]  wadr;
  logic [31:0] wdat;
  logic [31:0] rdata;

  // Classic Wishbone front end; a write takes effect only on the ack edge.
  // Reads have no side effect, so a repeated read is harmless.
  ccdo_wb_slave u_wb (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .cyc_i   (cyc_i),
    .stb_i   (stb_i),
    .we_i    (we_i),
    .sel_i   (sel_i),
    .adr_i   (adr_i),
    .dat_i   (dat_i),
    .rdata_i (rdata),
    .ack_o   (ack_o),
    .dat_o   (dat_o),
    .wr_o    (wr_p),
    .rd_o    (rd_p),
    .wadr_o  (wadr),
    .wdat_o  (wdat)
  );

  // ==========================================================================
  // Decode helpers
  // ==========================================================================
  // One-hot states; the second state is the call or squashed no-op slot.
  typedef enum logic [1:0] {
    CCDO_EXEC   = 2'b01,
    CCDO_SECOND = 2'b10
  } ccdo_state_t;

  // Matches the six-bit opcode field of the byte-wide file operations.
  function automatic logic is_op6(input logic [13:0] ins, input logic [5:0] op);
    is_op6 = (ins[13:OP6_LSB] == op);
  endfunction : is_op6

  // Zero test shared by complement and decrement; the two clears set the zero flag directly.
  function automatic logic all_zero(input logic [7:0] v);
    all_zero = (v == BYTE_ZERO);
  endfunction : all_zero

  // ==========================================================================
  // Core state
  // ==========================================================================
  // Architectural registers, each with its next value except busy_ff.
  ccdo_state_t state_ff;
  ccdo_state_t nxt_state;
  logic [7:0]  w_ff;
  logic [7:0]  nxt_w;
  logic [14:0] pc_ff;
  logic [14:0] nxt_pc;
  logic [7:0]  pc_high_latch_ff;
  logic [7:0]  nxt_pc_high_latch;
  logic [7:0]  status_ff;
  logic [7:0]  nxt_status;
  logic [14:0] top_ff;
  logic [14:0] nxt_top;
  logic [7:0]  fdat_ff;
  logic [7:0]  nxt_fdat;
  logic [7:0]  fout_ff;
  logic [7:0]  nxt_fout;
  logic        wdt_ff;
  logic        nxt_wdt;
  logic        push_ff;
  logic        nxt_push;
  logic        fwe_ff;
  logic        nxt_fwe;
  logic [6:0]  faddr_ff;
  logic [6:0]  nxt_faddr;
  logic        busy_ff;

  // Both results are formed every cycle; decode only picks one.
  logic [13:0] ins;
  logic        issue;
  logic [7:0]  dec_res;
  logic [7:0]  cmp_res;
  logic        dest_f;

  assign ins     = wdat[13:0];
  assign issue   = wr_p & (wadr == ADDR_INSTR) & (state_ff == CCDO_EXEC);
  assign dec_res = fdat_ff - BYTE_ONE;
  assign cmp_res = ~fdat_ff;
  assign dest_f  = ins[DEST_BIT];

  // Next-state logic: an instruction word written to ADDR_INSTR executes at once.
  // Writes while the second cycle runs are ignored so the squashed slot stays a no-op.
  always_comb begin
    nxt_state  = state_ff;
    nxt_w      = w_ff;
    nxt_pc     = pc_ff;
    nxt_pc_high_latch = pc_high_latch_ff;
    nxt_status = status_ff;
    nxt_top    = top_ff;
    nxt_fdat   = fdat_ff;
    nxt_fout   = fout_ff;
    nxt_wdt    = 1'b0;
    nxt_push   = 1'b0;
    nxt_fwe    = 1'b0;
    nxt_faddr  = faddr_ff;
    unique case (state_ff)
      CCDO_SECOND: begin
        nxt_state = CCDO_EXEC;
      end
      CCDO_EXEC: begin
        if (issue) begin
          nxt_pc    = pc_ff + PC_ONE;
          nxt_faddr = ins[6:0];
          if (ins == OP_WATCHDOG_CLEAR) begin
            nxt_wdt = 1'b1;                                               // RULE1
            nxt_status[ST_TIMEOUT] = 1'b1;                                // RULE2
            nxt_status[ST_POWERDN] = 1'b1;                                // RULE2
          end else if (ins == OP_CALL_VIA_W) begin
            nxt_top   = pc_ff + PC_ONE;                                   // RULE3
            nxt_push  = 1'b1;                                             // RULE3
            nxt_pc    = {pc_high_latch_ff[6:0], w_ff};                           // RULE4
            nxt_state = CCDO_SECOND;                                      // RULE5
          end else if (ins == OP_CLEAR_W) begin
            nxt_w = BYTE_ZERO;                                            // RULE9
            nxt_status[ST_ZERO] = 1'b1;                                   // RULE9
          end else if (ins[13:OP7_LSB] == OP7_CLEAR_FILE) begin
            nxt_fwe  = 1'b1;                                              // RULE8
            nxt_fout = BYTE_ZERO;                                         // RULE8
            nxt_status[ST_ZERO] = 1'b1;                                   // RULE8
          end else if (is_op6(ins, OP6_COMPLEMENT)) begin
            if (dest_f) begin
              nxt_fwe  = 1'b1;                                            // RULE6
              nxt_fout = cmp_res;                                         // RULE7
            end else begin
              nxt_w = cmp_res;                                            // RULE6
            end
            nxt_status[ST_ZERO] = all_zero(cmp_res);                      // RULE12
          end else if (is_op6(ins, OP6_DECREMENT) || is_op6(ins, OP6_DEC_SKIP)) begin
            if (dest_f) begin
              nxt_fwe  = 1'b1;                                            // RULE6
              nxt_fout = dec_res;                                         // RULE10
            end else begin
              nxt_w = dec_res;                                            // RULE10
            end
            if (is_op6(ins, OP6_DECREMENT)) begin
              nxt_status[ST_ZERO] = all_zero(dec_res);                    // RULE12
            end else if (all_zero(dec_res)) begin
              nxt_pc    = pc_ff + 15'h0002;                               // RULE11
              nxt_state = CCDO_SECOND;                                    // RULE11
            end
          end
        end
        // Software access to the architectural registers outside execution.
        if (wr_p && !issue) begin
          unique case (wadr)
            ADDR_WREG:    nxt_w      = wdat[7:0];
            ADDR_PC:      nxt_pc     = wdat[14:0];
            ADDR_PC_HIGH_LATCH:  nxt_pc_high_latch = {1'b0, wdat[6:0]};
            ADDR_STATUS:  nxt_status = wdat[7:0];
            ADDR_FILEDAT: nxt_fdat   = wdat[7:0];
            default:      nxt_fdat   = fdat_ff;
          endcase
        end
        // A written file result also becomes the operand for the next instruction.
        if (nxt_fwe) begin
          nxt_fdat = nxt_fout;
        end
      end
      default: begin
        nxt_state = CCDO_EXEC;
      end
    endcase
  end

  // Registers only; all decisions are made in the process above.
  // Reset sets the timeout and powerdown flags, puts the state in CCDO_EXEC and clears everything else.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff  <= CCDO_EXEC;
      w_ff      <= BYTE_ZERO;
      pc_ff     <= PC_RST;
      pc_high_latch_ff <= BYTE_ZERO;
      status_ff <= STATUS_RST;
      top_ff    <= PC_RST;
      fdat_ff   <= BYTE_ZERO;
      fout_ff   <= BYTE_ZERO;
      wdt_ff    <= 1'b0;
      push_ff   <= 1'b0;
      fwe_ff    <= 1'b0;
      faddr_ff  <= 7'h00;
      busy_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      w_ff      <= nxt_w;
      pc_ff     <= nxt_pc;
      pc_high_latch_ff <= nxt_pc_high_latch;
      status_ff <= nxt_status;
      top_ff    <= nxt_top;
      fdat_ff   <= nxt_fdat;
      fout_ff   <= nxt_fout;
      wdt_ff    <= nxt_wdt;
      push_ff   <= nxt_push;
      fwe_ff    <= nxt_fwe;
      faddr_ff  <= nxt_faddr;
      busy_ff   <= (nxt_state == CCDO_SECOND);
    end
  end

  // ==========================================================================
  // Outputs and read mux
  // ==========================================================================
  // Both watchdog clears share one pulse, so counter and prescaler
  // can never be cleared apart.
  assign wdt_clear_o       = wdt_ff;                                      // RULE1
  assign wdt_presc_clear_o = wdt_ff;                                      // RULE1
  assign stack_push_o      = push_ff;
  assign stack_data_o      = top_ff;
  assign file_we_o         = fwe_ff;
  assign file_addr_o       = faddr_ff;
  assign file_wdata_o      = fout_ff;
  assign busy_o            = busy_ff;

  // Read mux follows the held address, so the slave registers the data
  // on the same edge that raises ack, without a wait state.
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (wadr)
      ADDR_WREG:    rdata[7:0]  = w_ff;
      ADDR_PC:      rdata[14:0] = pc_ff;
      ADDR_PC_HIGH_LATCH:  rdata[7:0]  = pc_high_latch_ff;
      ADDR_STATUS:  rdata[7:0]  = status_ff;
      ADDR_TOP:     rdata[14:0] = top_ff;
      ADDR_FILEDAT: rdata[7:0]  = fdat_ff;
      ADDR_FILEOUT: rdata[7:0]  = fout_ff;
      default:      rdata       = 32'h0000_0000;
    endcase
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  // Each check looks one cycle after the executing edge, operands via $past.
  // Status bits other than the two flags a watchdog clear may set.
  logic [5:0]  st_rest;
  assign st_rest = {status_ff[7:ST_TIMEOUT+1], status_ff[ST_POWERDN-1:0]};

  a_wdt_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    wdt_ff |-> status_ff[ST_TIMEOUT] && status_ff[ST_POWERDN]) else $error("watchdog clear left flags");
  a_wdt_rest: assert property (@(posedge clk_i) disable iff (rst_i) // RULE2
    wdt_ff |-> $stable(st_rest)) else $error("watchdog clear changed other status");
  a_wdt_zero_kept: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    wdt_ff |-> $stable(w_ff)) else $error("watchdog clear touched W");
  a_wdt_out: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    issue && ins == OP_WATCHDOG_CLEAR |=> wdt_clear_o && wdt_presc_clear_o)
    else $error("watchdog not cleared");
  a_wdt_pulse: assert property (@(posedge clk_i) disable iff (rst_i) // RULE1
    wdt_ff |=> !wdt_ff) else $error("watchdog clear longer than one cycle");

  a_call_push: assert property (@(posedge clk_i) disable iff (rst_i) // RULE3
    push_ff |-> top_ff == $past(pc_ff) + PC_ONE) else $error("bad return address");
  a_call_target: assert property (@(posedge clk_i) disable iff (rst_i) // RULE4
    push_ff |-> pc_ff == {$past(pc_high_latch_ff[6:0]), $past(w_ff)}) else $error("bad call target");
  a_call_two: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
    push_ff |-> busy_ff && $stable(status_ff)) else $error("call not two cycles");
  a_plain_one: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    issue && ins != OP_CALL_VIA_W && !is_op6(ins, OP6_DEC_SKIP) |=> !busy_ff && pc_ff == $past(pc_ff) + PC_ONE)
    else $error("plain instruction not one cycle");

  a_clear_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE8
    issue && ins[13:OP7_LSB] == OP7_CLEAR_FILE |=> fwe_ff && fout_ff == BYTE_ZERO && status_ff[ST_ZERO])
    else $error("clear file wrong");
  a_clear_w: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
    issue && ins == OP_CLEAR_W |=> w_ff == BYTE_ZERO && status_ff[ST_ZERO]) else $error("clear W wrong");

  a_comp_dest: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    issue && is_op6(ins, OP6_COMPLEMENT) && !dest_f |=> w_ff == ~$past(fdat_ff) && !fwe_ff)
    else $error("complement to W wrong");
  a_comp_file: assert property (@(posedge clk_i) disable iff (rst_i) // RULE7
    issue && is_op6(ins, OP6_COMPLEMENT) && dest_f |=> fwe_ff && fout_ff == ~$past(fdat_ff))
    else $error("complement to file wrong");

  a_dec_zflag: assert property (@(posedge clk_i) disable iff (rst_i) // RULE12
    issue && is_op6(ins, OP6_DECREMENT) |=> status_ff[ST_ZERO] == ($past(fdat_ff) == BYTE_ONE))
    else $error("decrement zero flag wrong");
  a_dec_dest: assert property (@(posedge clk_i) disable iff (rst_i) // RULE10
    issue && is_op6(ins, OP6_DECREMENT) && dest_f |=> fwe_ff && fout_ff == $past(dec_res))
    else $error("decrement to file wrong");
  a_skip_nostat: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    issue && is_op6(ins, OP6_DEC_SKIP) |=> $stable(status_ff) && busy_ff == ($past(dec_res) == BYTE_ZERO))
    else $error("skip behaviour wrong");
  a_skip_w: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
    issue && is_op6(ins, OP6_DEC_SKIP) && !dest_f |=> w_ff == $past(dec_res) && !fwe_ff)
    else $error("skip to W wrong");
  a_dest_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
    fwe_ff |-> $stable(w_ff)) else $error("file write also changed W");

  // Covers for call, squashed slot, watchdog clear, file complement and a status read.
  c_call: cover property (@(posedge clk_i) disable iff (rst_i) push_ff ##1 !busy_ff);
  c_skip: cover property (@(posedge clk_i) disable iff (rst_i) issue && is_op6(ins, OP6_DEC_SKIP) ##1 busy_ff);
  c_wdt:  cover property (@(posedge clk_i) disable iff (rst_i) wdt_ff);
  c_comp: cover property (@(posedge clk_i) disable iff (rst_i) issue && is_op6(ins, OP6_COMPLEMENT) && dest_f);
  c_read: cover property (@(posedge clk_i) disable iff (rst_i) rd_p && wadr == ADDR_STATUS);

endmodule : ccdo_core

// >>> testbench/ccdo_core_tb.sv
// Self-checking testbench for the clear/complement/decrement execution block.
module ccdo_core_tb import ccdo_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Stimulus, observed outputs and bookkeeping
  // ==========================================================================
  logic        clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [3:0]  sel_i;
  logic [7:0]  adr_i;
  logic [31:0] dat_i, dat_o;
  logic        ack_o, wdt_clear_o, wdt_presc_clear_o, stack_push_o, file_we_o, busy_o;
  logic [14:0] stack_data_o, s_sdat;
  logic [6:0]  file_addr_o, s_fadr;
  logic [7:0]  file_wdata_o, s_fdat;
  logic        s_fwe, s_push, s_wclr, s_pclr, s_busy;
  logic [31:0] pc0, rd_w, rd_st, rd_pc, q;
  int          failures, tests_run, cycles;

  ccdo_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i),
    .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o), .wdt_clear_o(wdt_clear_o),
    .wdt_presc_clear_o(wdt_presc_clear_o), .stack_push_o(stack_push_o), .stack_data_o(stack_data_o),
    .file_we_o(file_we_o), .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .busy_o(busy_o));

  // The 40 ns clock for the 25 MHz core.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Hang guard: the whole run needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("ERROR %0t: run did not finish", $time);
      close_out();
    end
  end

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  // Compares a seen value with the expected one and counts both outcomes.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // One classic cycle; the request holds until ack is sampled high, so no cycle count is assumed.
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
    // The execution strobes are one-cycle pulses, so they are caught in the cycle after the ack.
    if (wr && a == ADDR_INSTR) begin
      s_fwe  = file_we_o;
      s_fadr = file_addr_o;
      s_fdat = file_wdata_o;
      s_push = stack_push_o;
      s_sdat = stack_data_o;
      s_wclr = wdt_clear_o;
      s_pclr = wdt_presc_clear_o;
      s_busy = busy_o;
    end
  endtask : wb

  // Loads operands, executes one opcode and reads back W, status and the program counter.
  task automatic run(input logic [13:0] op, input logic [7:0] fv, input logic [7:0] wv, input logic [7:0] st);
    wb(1'b1, ADDR_FILEDAT, {24'h0, fv}, 4'hf);
    wb(1'b1, ADDR_WREG, {24'h0, wv}, 4'hf);
    wb(1'b1, ADDR_STATUS, {24'h0, st}, 4'hf);
    wb(1'b0, ADDR_PC, 32'h0, 4'hf);
    pc0 = q;
    wb(1'b1, ADDR_INSTR, {18'h0, op}, 4'hf);
    wb(1'b0, ADDR_WREG, 32'h0, 4'hf);
    rd_w = q;
    wb(1'b0, ADDR_STATUS, 32'h0, 4'hf);
    rd_st = q;
    wb(1'b0, ADDR_PC, 32'h0, 4'hf);
    rd_pc = q;
  endtask : run

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_watchdog();
    wb(1'b0, ADDR_STATUS, 32'h0, 4'hf);
    chk(q, {24'h0, STATUS_RST}, "status after reset");
    run(OP_WATCHDOG_CLEAR, 8'h5a, 8'h3c, 8'h04);
    chk({31'h0, s_wclr}, 32'h1, "watchdog counter clear");
    chk({31'h0, s_pclr}, 32'h1, "watchdog prescaler clear");
    chk(rd_st, 32'h1c, "status after watchdog clear");
    chk({31'h0, s_busy}, 32'h0, "watchdog clear busy");
    chk(rd_pc, {17'h0, pc0[14:0] + 15'h1}, "pc after watchdog clear");
    $display("test watchdog done");
  endtask : t_watchdog

  task automatic t_call_via_working_instr();
    wb(1'b1, ADDR_PC_HIGH_LATCH, 32'h5a, 4'hf);
    wb(1'b1, ADDR_PC, 32'h12ff, 4'hf);
    run(OP_CALL_VIA_W, 8'h00, 8'ha5, 8'h1c);
    chk({31'h0, s_push}, 32'h1, "push pulse");
    chk({17'h0, s_sdat}, 32'h1300, "pushed address");
    wb(1'b0, ADDR_TOP, 32'h0, 4'hf);
    chk(q, 32'h1300, "stack top");
    chk(rd_pc, 32'h5aa5, "call target");
    chk({31'h0, s_busy}, 32'h1, "call second cycle");
    chk(rd_st, 32'h1c, "status after call");
    $display("test call via working done");
  endtask : t_call_via_working_instr

  // Complement and decrement, both destinations, with results on either side of zero.
  task automatic t_file();
    logic [5:0] t_op [4] = '{OP6_COMPLEMENT, OP6_COMPLEMENT, OP6_DECREMENT, OP6_DECREMENT};
    logic       t_d [4]  = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] t_v [4]  = '{8'hff, 8'h5a, 8'h01, 8'h00};
    logic [7:0] res;
    logic [6:0] f;
    for (int i = 0; i < 4; i++) begin
      f   = 7'h40 + 7'(i);
      res = (t_op[i] == OP6_COMPLEMENT) ? ~t_v[i] : t_v[i] - 8'h01;
      // Zero flag is preset opposite to the expectation so a missing update shows.
      run({t_op[i], t_d[i], f}, t_v[i], 8'h77, (res == 8'h00) ? 8'h18 : 8'h1c);
      chk(rd_st, (res == 8'h00) ? 32'h1c : 32'h18, "zero flag");
      chk({31'h0, s_fwe}, {31'h0, t_d[i]}, "file write select");
      chk(rd_w, t_d[i] ? 32'h77 : {24'h0, res}, "working result");
      if (t_d[i]) begin
        chk({25'h0, s_fadr}, {25'h0, f}, "file address");
        chk({24'h0, s_fdat}, {24'h0, res}, "file result");
      end
      chk(rd_pc, {17'h0, pc0[14:0] + 15'h1}, "single cycle pc");
      chk({31'h0, s_busy}, 32'h0, "single cycle busy");
    end
    $display("test complement and decrement done");
  endtask : t_file

  task automatic t_clear();
    run({OP7_CLEAR_FILE, 7'h7f}, 8'h33, 8'h44, 8'h00);
    chk({31'h0, s_fwe}, 32'h1, "clear file write");
    chk({25'h0, s_fadr}, 32'h7f, "clear file address");
    chk({24'h0, s_fdat}, 32'h0, "clear file data");
    chk(rd_st, 32'h04, "clear file zero flag");
    chk(rd_w, 32'h44, "clear file leaves working");
    run(OP_CLEAR_W, 8'h33, 8'h9c, 8'h18);
    chk(rd_w, 32'h0, "clear working");
    chk(rd_st, 32'h1c, "clear working zero flag");
    chk({31'h0, s_fwe}, 32'h0, "clear working file write");
    $display("test clear done");
  endtask : t_clear

  task automatic t_skip();
    run({OP6_DEC_SKIP, 1'b1, 7'h21}, 8'h01, 8'h66, 8'h00);
    chk({31'h0, s_fwe}, 32'h1, "skip file write");
    chk({24'h0, s_fdat}, 32'h0, "skip file result");
    chk(rd_st, 32'h0, "skip leaves flags");
    chk({31'h0, s_busy}, 32'h1, "skip squash cycle");
    chk(rd_pc, {17'h0, pc0[14:0] + 15'h2}, "skip pc");
    run({OP6_DEC_SKIP, 1'b0, 7'h22}, 8'h02, 8'h66, 8'h04);
    chk(rd_w, 32'h01, "no skip working result");
    chk(rd_st, 32'h04, "no skip leaves flags");
    chk({31'h0, s_busy}, 32'h0, "no skip busy");
    chk(rd_pc, {17'h0, pc0[14:0] + 15'h1}, "no skip pc");
    $display("test decrement skip done");
  endtask : t_skip

  // Unmapped reads give zero and a write without the low byte lane changes nothing.
  task automatic t_bus();
    wb(1'b0, 8'h20, 32'h0, 4'hf);
    chk(q, 32'h0, "unmapped read");
    wb(1'b1, ADDR_WREG, 32'h11, 4'hf);
    wb(1'b1, ADDR_WREG, 32'hee, 4'he);
    wb(1'b0, ADDR_WREG, 32'h0, 4'hf);
    chk(q, 32'h11, "lane gated write");
    $display("test bus done");
  endtask : t_bus

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    sel_i = 4'h0;
    adr_i = 8'h00;
    dat_i = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_watchdog();
    t_call_via_working_instr();
    t_file();
    t_clear();
    t_skip();
    t_bus();
    close_out();
  end
endmodule : ccdo_core_tb
